// file: bench/eam_chk_monitor.sv
// Purpose: port-level checks on the alarm and e-bit monitor
// Assumes: control word shadowed from writes to offset 0
// Notes: bound from the bench top
`timescale 1ns/1ps
module eam_chk
  import eam_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire eam_rx_ev_t rx_ev_in,
  input wire eam_ctl_t ctl_out,
  input wire logic signal_lost_flag_out
);
  logic [13:0] ctrl;
  logic lost;
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  assign lost = rx_ev_in.frame_lost | rx_ev_in.mframe_lost;
  // shadow lets each check name its control cause exactly
  always_ff @(posedge clk_in) begin
    if (reset_in) ctrl <= 14'h0000;
    else if (reg_wr_in && reg_addr_in == 8'h00) ctrl <= reg_wdata_in[13:0];
  end
  AST_EBIT_LOST:
    assert property (lost |=> ctl_out.ebit13 == $past(ctrl[0]) && ctl_out.ebit15 == $past(ctrl[0]))
    else $error("e-bits off polarity while unaligned");
  AST_EBIT_MANUAL:
    assert property (!lost && !ctrl[1] |=> {ctl_out.ebit15, ctl_out.ebit13} == $past(ctrl[3:2]))
    else $error("manual e-bits differ from control");
  AST_AUTO_RA:
    assert property (ctrl[7] |=> ctl_out.remote_alarm == $past(rx_ev_in.frame_lost))
    else $error("auto remote alarm wrong");
  AST_RX_AIS:
    assert property (1'b1 |=> ctl_out.rx_force_ais == $past(rx_ev_in.frame_lost && !ctrl[8]))
    else $error("system side ais wrong");
  AST_ALL_ONES:
    assert property ($changed(ctrl[4]) |=> ctl_out.send_all_ones == $past(ctrl[4]))
    else $error("all-ones send wrong");
  AST_FAR16:
    assert property (1'b1 |=> ctl_out.slot16_far_alarm == $past(ctrl[12]))
    else $error("slot-16 far alarm send wrong");
  AST_DCO:
    assert property (ctl_out.dco_master ==
                     ($past(ctrl[9]) || (signal_lost_flag_out && !$past(ctrl[10]))))
    else $error("clock fallback wrong");
  AST_FREEZE:
    assert property (rx_ev_in.slip |=> ctl_out.sig_freeze == !$past(ctrl[11]))
    else $error("freeze on slip wrong");
  cover property ($rose(signal_lost_flag_out));
  cover property ($rose(ctl_out.sig_freeze));
  cover property ($rose(ctl_out.rx_force_ais));
endmodule

// file: bench/eam_line_model.sv
// Purpose: remote e1 terminal feeding receive events
// Assumes: one pulse period every four clocks
// Notes: e-bits only on command, so counts stay exact
`timescale 1ns/1ps
module eam_line_model
  import eam_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic line_ones_in,
  input wire logic align_lost_in,
  input wire logic ebit_go_in,
  input wire logic smf_bad_in,
  output eam_rx_ev_t ev_out
);
  logic [1:0] phase;
  logic second;
  // strobes last one cycle; levels follow the commands
  always_ff @(posedge clk_in) begin
    ev_out <= '0;
    phase <= reset_in ? 2'h0 : phase + 2'h1;
    second <= reset_in ? 1'b0 : second ^ ebit_go_in;
    ev_out.frame_lost <= align_lost_in & !reset_in;
    ev_out.mframe_lost <= align_lost_in & !reset_in;
    if (!reset_in && phase == 2'h3) begin
      ev_out.bit_strobe <= 1'b1;
      ev_out.bit_one <= line_ones_in;
    end
    if (!reset_in && ebit_go_in) begin
      ev_out.smf_strobe <= 1'b1;
      ev_out.smf_second <= second;
      ev_out.smf_error <= smf_bad_in;
      ev_out.ebit_strobe <= 1'b1;
      ev_out.ebit_value <= !smf_bad_in;
    end
  end
endmodule

// file: bench/tb_top.sv
// Purpose: self-checking bench for the alarm and e-bit monitor
// Assumes: ais period shortened to 40 clocks
// Notes: read results queued and checked by a watcher
`timescale 1ns/1ps
module tb_top;
  import eam_pkg::*;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h00000000;
  logic wr = 0, rd = 0, ones = 1, lost = 0, ego = 0, bad = 0, slip = 0, p1 = 0;
  logic [31:0] rdata, r;
  logic [127:0] sig;
  eam_rx_ev_t m_ev, rx_ev;
  eam_tx_ev_t tx_ev = '0;
  eam_ctl_t ctl;
  logic [31:0] q[$];
  int mismatches = 0, samples_checked = 0;
  // clock and event merge
  initial forever #4 clk_in = ~clk_in;
  always_comb begin
    rx_ev = m_ev;
    rx_ev.slip = slip;
  end
  eam_line_model u_line (.clk_in(clk_in), .reset_in(reset_in), .line_ones_in(ones),
    .align_lost_in(lost), .ebit_go_in(ego), .smf_bad_in(bad), .ev_out(m_ev));
  eam_monitor #(.AIS_PERIOD_CYCLES(40)) u_dut (.clk_in(clk_in), .reset_in(reset_in),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_rdata_out(rdata), .rx_ev_in(rx_ev), .tx_ev_in(tx_ev), .ctl_out(ctl),
    .tx_signaling_regs_out(sig), .ais_state_flag_out(), .signal_lost_flag_out());
  task automatic cmp(input string what, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask
  // gap cycle after each strobe keeps one assignment per step
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
    q.push_back(e);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // read data stand only in the cycle after the strobe, so take them at that edge
  always @(posedge clk_in) begin
    p1 <= rd;
    if (p1) cmp("read data", q.pop_front(), rdata);
  end
  // watchdog well past the expected run of about 600 clocks
  initial begin
    #100000;
    mismatches++;
    summarize();
  end
  initial begin
    void'($urandom(32'h04C26603));
    tick(12);
    reset_in <= 1'b0;
    tick(1);
    rd_reg(8'h04, 32'h00000FFF);
    rd_reg(8'h08, 32'h00000000);
    rd_reg(8'h20, 32'h00000000);
    $display("test defaults done");
    wr_reg(8'h04, 32'h00001000);
    ones <= 1'b0;
    tick(50);
    rd_reg(8'h08, 32'h00000000);
    tick(30);
    rd_reg(8'h08, 32'h00000002);
    ones <= 1'b1;
    rd_reg(8'h08, 32'h00000002);
    tick(20);
    rd_reg(8'h08, 32'h00000000);
    rd_reg(8'h0C, 32'h00000002);
    wr_reg(8'h0C, 32'h00000002);
    rd_reg(8'h0C, 32'h00000000);
    $display("test signal loss done");
    lost <= 1'b1;
    tick(100);
    rd_reg(8'h08, 32'h00000001);
    rd_reg(8'h0C, 32'h00000001);
    ones <= 1'b0;
    lost <= 1'b0;
    tick(90);
    rd_reg(8'h08, 32'h00000002);
    wr_reg(8'h00, 32'h00000040);
    ones <= 1'b1;
    tick(130);
    rd_reg(8'h08, 32'h00000001);
    $display("test ais done");
    tx_ev.bit_strobe <= 1'b1;
    tick(28);
    rd_reg(8'h08, 32'h00000001);
    tick(3);
    rd_reg(8'h08, 32'h00000081);
    tx_ev.bit_pulse <= 1'b1;
    tick(2);
    rd_reg(8'h08, 32'h00000001);
    tx_ev <= '0;
    $display("test zero run done");
    repeat (8) begin
      r = $urandom & 32'h00003FFF;
      wr_reg(8'h00, r);
      lost <= r[5] ^ r[2];
      slip <= 1'b1;
      tick(1);
      slip <= 1'b0;
      rd_reg(8'h00, r);
    end
    lost <= 1'b0;
    $display("test control done");
    for (int g = 0; g < 16; g++) wr_reg(8'h40 + 8'(4 * g), 32'h000000FF);
    cmp("signaling", 32'hFFFFFFFF, {32{&sig}});
    rd_reg(8'h7C, 32'h000000FF);
    rd_reg(8'h41, 32'h00000000);
    $display("test signaling done");
    bad <= 1'b1;
    for (int k = 0; k < 5; k++) begin
      lost <= (k == 3);
      bad <= (k != 4);
      ego <= 1'b1;
      tick(1);
      ego <= 1'b0;
      tick(1);
    end
    lost <= 1'b0;
    rd_reg(8'h10, 32'h00000003);
    rd_reg(8'h10, 32'h00000000);
    $display("test e-bit count done");
    tick(3);
    summarize();
  end
endmodule
bind eam_monitor eam_chk u_chk (.clk_in(clk_in), .reset_in(reset_in),
  .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
  .rx_ev_in(rx_ev_in), .ctl_out(ctl_out), .signal_lost_flag_out(signal_lost_flag_out));

// file: src/eam_defines.svh
// Purpose: constants for the e1 alarm and e-bit monitor
// Assumes: byte addresses on a 32-bit register port
// Notes: definitions only
`ifndef EAM_DEFINES_SVH
`define EAM_DEFINES_SVH

// register byte offsets
`define EAM_ADDR_CTRL 8'h00
`define EAM_ADDR_LOS_CFG 8'h04
`define EAM_ADDR_STATUS 8'h08
`define EAM_ADDR_IRQ 8'h0C
`define EAM_ADDR_EBIT_CNT 8'h10
`define EAM_ADDR_SIG_BASE 8'h40
`define EAM_ADDR_SIG_LAST 8'h7C

// control register fields
`define EAM_C_EBP 0
`define EAM_C_AXS 1
`define EAM_C_TX_EBIT_FRAME13 2
`define EAM_C_TX_EBIT_FRAME15 3
`define EAM_C_XAIS 4
`define EAM_C_XRA 5
`define EAM_C_ALM 6
`define EAM_C_AXRA 7
`define EAM_C_DAIS 8
`define EAM_C_MAS 9
`define EAM_C_DCS 10
`define EAM_C_DAF 11
`define EAM_C_RA16 12
`define EAM_C_TSIS 13
`define EAM_CTRL_W 14
`define EAM_CTRL_RST 14'h0000

// loss-of-signal config fields and reset (window 4096, one pulse)
`define EAM_LOSW_LSB 0
`define EAM_LOSW_MSB 11
`define EAM_LOSN_LSB 12
`define EAM_LOSN_MSB 19
`define EAM_LOSW_RST 12'hFFF
`define EAM_LOSN_RST 8'h00
`define EAM_LOSW_MIN 12'h00F

// status register bits
`define EAM_S_AIS 0
`define EAM_S_LOS 1
`define EAM_S_RRA 2
`define EAM_S_AIS16 3
`define EAM_S_LOS16 4
`define EAM_S_RA16 5
`define EAM_S_XLS 6
`define EAM_S_XLO 7
`define EAM_S_SI1 8
`define EAM_S_SI2 9
`define EAM_STAT_W 10

// interrupt flag bits
`define EAM_I_AIS 0
`define EAM_I_LOS 1
`define EAM_I_RA 2
`define EAM_I_RAR 3
`define EAM_I_AIS16 4
`define EAM_I_RA16 5
`define EAM_I_XLSC 6
`define EAM_I_RMB 7
`define EAM_I_XMB 8
`define EAM_IRQ_W 9

// alarm thresholds
`define EAM_AIS_ZEROS 2'h3
`define EAM_TS16_ZEROS 3'h4
`define EAM_TS16_LOS_OCT 5'h10
`define EAM_XLS_PERIODS 2'h3
`define EAM_XLO_ZEROS 6'h20
`define EAM_AIS_PERIOD_NS 250000
`define EAM_CLK_MHZ 125
`endif

// file: src/eam_monitor.sv
// Purpose: e1 receive alarm supervision, e-bit insertion and counting
// Assumes: event strobes are one cycle wide and synchronous to clk_in; loss, current and limiter inputs are levels
// Notes: registers on a plain strobe port, read data one cycle late
// Functional notes
// - frame-13 e-bit carries submultiframe one status, frame-15 carries submultiframe two
// - e-bit is one when submultiframe had no crc error, zero otherwise
// - with multiframe alignment held, standard e-bit handling ignores polarity select
// - auto insertion places received submultiframe status into outgoing e-bits
// - alignment lost: all e-bits sent at the selected polarity
// - 16-bit counter counts received zero e-bits only in multiframe alignment
// - incoming ais shown in status and irq; all-ones sent when enabled
// - los after no pulses in window; clear on enough ones in window
// - select zero: ais on under 3 zeros per 250 us with frame lost
// - select one: ais needs two consecutive periods, clear likewise
// - remote alarm follows bit 3 of non-alignment time-slot-0 octets
// - slot-16 remote alarm follows received y-bit of cas alignment word
// - slot-16 silence after 16 zero octets, cleared by any one
// - slot-16 ais on under 4 zeros two multiframes, off above 3
// - line short after over 3 high-current periods, off when limiter idle
// - zero-run flag after 32 transmitted zeros, cleared by each pulse
// - software sends slot-16 ais or silence via signaling bytes; bit sends far alarm
// - auto remote alarm follows frame alignment loss
// - frame loss forces ais to system side unless disabled
// - slave dco falls back to master on los unless switch disabled
// - signaling buffer freezes on los, cas loss or slip unless disabled
`timescale 1ns/1ps
`include "eam_defines.svh"

module eam_monitor
  import eam_pkg::*;
#(
  parameter int AIS_PERIOD_CYCLES = `EAM_AIS_PERIOD_NS * `EAM_CLK_MHZ / 1000,
  parameter int EBIT_CNT_W = 16
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  input wire eam_rx_ev_t rx_ev_in,
  input wire eam_tx_ev_t tx_ev_in,
  output eam_ctl_t ctl_out,
  output logic [127:0] tx_signaling_regs_out,
  output logic ais_state_flag_out,
  output logic signal_lost_flag_out
);

  localparam int PW = $clog2(AIS_PERIOD_CYCLES);

  logic [`EAM_CTRL_W-1:0] ctrl;
  logic [11:0] los_window;
  logic [7:0] los_ones_need;
  logic [`EAM_STAT_W-1:0] status;
  logic [`EAM_IRQ_W-1:0] irq;
  logic [`EAM_IRQ_W-1:0] irq_set;
  logic [EBIT_CNT_W-1:0] ebit_zero_counter;
  logic [7:0] sig_reg [16];
  logic rx_submf1_err_flag;
  logic rx_submf2_err_flag;
  eam_los_st_t los_state;
  logic [12:0] los_period_cnt;
  logic [8:0] los_ones_cnt;
  logic [PW-1:0] ais_timer;
  logic [1:0] ais_zeros;
  logic ais_prev_low;
  logic ais_prev_high;
  logic ais_state_flag;
  logic remote_alarm_flag;
  logic slot16_far_alarm_flag;
  logic slot16_silence_flag;
  logic slot16_all_ones_flag;
  logic [4:0] ts16_zero_octets;
  logic [2:0] ts16_zero_bits;
  logic ts16_prev_low;
  logic tx_line_short_flag;
  logic [1:0] xls_cnt;
  logic tx_zero_run_flag;
  logic [5:0] xlo_cnt;
  logic slip_hold;
  logic wr_ctrl;
  logic wr_irq;
  logic rd_ebit;
  logic ais_period_end;
  logic ais_low;
  logic [3:0] ts16_zeros_now;
  logic [2:0] next_ts16_bits;
  logic next_ais;

  assign wr_ctrl = reg_wr_in && (reg_addr_in == `EAM_ADDR_CTRL);
  assign wr_irq = reg_wr_in && (reg_addr_in == `EAM_ADDR_IRQ);
  assign rd_ebit = reg_rd_in && (reg_addr_in == `EAM_ADDR_EBIT_CNT);

  // control and los config registers
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      ctrl <= `EAM_CTRL_RST;
      los_window <= `EAM_LOSW_RST;
      los_ones_need <= `EAM_LOSN_RST;
    end else if (wr_ctrl) begin
      ctrl <= reg_wdata_in[`EAM_CTRL_W-1:0];
    end else if (reg_wr_in && reg_addr_in == `EAM_ADDR_LOS_CFG) begin
      // windows shorter than 16 periods are raised to the minimum
      los_window <= (reg_wdata_in[`EAM_LOSW_MSB:`EAM_LOSW_LSB] < `EAM_LOSW_MIN) ?
                    `EAM_LOSW_MIN : reg_wdata_in[`EAM_LOSW_MSB:`EAM_LOSW_LSB];
      los_ones_need <= reg_wdata_in[`EAM_LOSN_MSB:`EAM_LOSN_LSB];
    end
  end

  // sixteen transmit signaling bytes, one word each
  genvar g;
  generate
    for (g = 0; g < 16; g++) begin : g_sig
      always_ff @(posedge clk_in) begin
        if (reset_in) begin
          sig_reg[g] <= 8'h00;
        end else if (reg_wr_in && reg_addr_in == `EAM_ADDR_SIG_BASE + 8'(g * 4)) begin
          sig_reg[g] <= reg_wdata_in[7:0];
        end
      end
      assign tx_signaling_regs_out[g*8 +: 8] = sig_reg[g];
    end
  endgenerate

  // received submultiframe crc status, one means errored
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      rx_submf1_err_flag <= 1'b0;
      rx_submf2_err_flag <= 1'b0;
    end else if (rx_ev_in.smf_strobe) begin
      if (rx_ev_in.smf_second) begin
        rx_submf2_err_flag <= rx_ev_in.smf_error;
      end else begin
        rx_submf1_err_flag <= rx_ev_in.smf_error;
      end
    end
  end

  // e-bit zero counter; saturates, clears on read but a same-cycle count survives
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      ebit_zero_counter <= '0;
    end else begin
      if (rx_ev_in.ebit_strobe && !rx_ev_in.ebit_value && !rx_ev_in.mframe_lost) begin
        if (rd_ebit) begin
          ebit_zero_counter <= EBIT_CNT_W'(1);
        end else if (ebit_zero_counter != '1) begin
          ebit_zero_counter <= ebit_zero_counter + EBIT_CNT_W'(1);
        end
      end else if (rd_ebit) begin
        ebit_zero_counter <= '0;
      end
    end
  end

  // loss of signal: zero run in a window sets, enough ones in a window clears
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      los_state <= EAM_LOS_CLEAR;
      los_period_cnt <= '0;
      los_ones_cnt <= '0;
    end else if (rx_ev_in.bit_strobe) begin
      unique case (los_state)
        EAM_LOS_CLEAR: begin
          los_ones_cnt <= '0;
          if (rx_ev_in.bit_one) begin
            los_period_cnt <= '0;
          end else if (los_period_cnt == {1'b0, los_window}) begin
            los_state <= EAM_LOS_SET;
            los_period_cnt <= '0;
          end else begin
            los_period_cnt <= los_period_cnt + 13'h0001;
          end
        end
        EAM_LOS_SET: begin
          if (rx_ev_in.bit_one && los_ones_cnt == {1'b0, los_ones_need}) begin
            los_state <= EAM_LOS_CLEAR;
            los_period_cnt <= '0;
            los_ones_cnt <= '0;
          end else if (los_period_cnt == {1'b0, los_window}) begin
            // window over without enough ones: start a fresh one
            los_period_cnt <= '0;
            los_ones_cnt <= '0;
          end else begin
            los_period_cnt <= los_period_cnt + 13'h0001;
            los_ones_cnt <= los_ones_cnt + {8'h00, rx_ev_in.bit_one};
          end
        end
      endcase
    end
  end

  // 250 us observation periods for ais, zeros saturate at the threshold
  assign ais_period_end = (ais_timer == PW'(AIS_PERIOD_CYCLES - 1));
  assign ais_low = (ais_zeros < `EAM_AIS_ZEROS);

  always_comb begin
    next_ais = ais_state_flag;
    if (!ctrl[`EAM_C_ALM]) begin
      if (ais_low && rx_ev_in.frame_lost) begin
        next_ais = 1'b1;
      end else if (!ais_low) begin
        next_ais = 1'b0;
      end
    end else begin
      if (ais_low && ais_prev_low) begin
        next_ais = 1'b1;
      end else if (!ais_low && ais_prev_high) begin
        next_ais = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      ais_timer <= '0;
      ais_zeros <= '0;
      ais_prev_low <= 1'b0;
      ais_prev_high <= 1'b0;
      ais_state_flag <= 1'b0;
    end else if (ais_period_end) begin
      ais_timer <= '0;
      ais_zeros <= '0;
      ais_prev_low <= ais_low;
      ais_prev_high <= !ais_low;
      ais_state_flag <= next_ais;
    end else begin
      ais_timer <= ais_timer + PW'(1);
      if (rx_ev_in.bit_strobe && !rx_ev_in.bit_one && ais_zeros != `EAM_AIS_ZEROS) begin
        ais_zeros <= ais_zeros + 2'h1;
      end
    end
  end

  // remote alarms from time slot 0 and the cas alignment word
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      remote_alarm_flag <= 1'b0;
      slot16_far_alarm_flag <= 1'b0;
    end else begin
      if (rx_ev_in.nfas_strobe) begin
        remote_alarm_flag <= rx_ev_in.nfas_bit3;
      end
      if (rx_ev_in.mfaw_strobe) begin
        slot16_far_alarm_flag <= rx_ev_in.mfaw_y;
      end
    end
  end

  // time-slot-16 silence and all-ones supervision
  always_comb begin
    ts16_zeros_now = 4'h0;
    for (int i = 0; i < 8; i++) begin
      ts16_zeros_now = ts16_zeros_now + {3'h0, !rx_ev_in.ts16_data[i]};
    end
    next_ts16_bits = ts16_zero_bits;
    if (rx_ev_in.ts16_strobe) begin
      // count saturates at the threshold, the exact figure is not needed
      if ({1'b0, ts16_zero_bits} + ts16_zeros_now >= {1'b0, `EAM_TS16_ZEROS}) begin
        next_ts16_bits = `EAM_TS16_ZEROS;
      end else begin
        next_ts16_bits = ts16_zero_bits + ts16_zeros_now[2:0];
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      slot16_silence_flag <= 1'b0;
      ts16_zero_octets <= '0;
      ts16_zero_bits <= '0;
      ts16_prev_low <= 1'b0;
      slot16_all_ones_flag <= 1'b0;
    end else begin
      if (rx_ev_in.ts16_strobe) begin
        if (rx_ev_in.ts16_data != 8'h00) begin
          ts16_zero_octets <= '0;
          slot16_silence_flag <= 1'b0;
        end else if (ts16_zero_octets == `EAM_TS16_LOS_OCT - 5'h01) begin
          ts16_zero_octets <= `EAM_TS16_LOS_OCT;
          slot16_silence_flag <= 1'b1;
        end else if (ts16_zero_octets != `EAM_TS16_LOS_OCT) begin
          ts16_zero_octets <= ts16_zero_octets + 5'h01;
        end
      end
      if (rx_ev_in.cas_end) begin
        ts16_zero_bits <= '0;
        ts16_prev_low <= (next_ts16_bits < `EAM_TS16_ZEROS);
        if (next_ts16_bits < `EAM_TS16_ZEROS && ts16_prev_low) begin
          slot16_all_ones_flag <= 1'b1;
        end else if (next_ts16_bits >= `EAM_TS16_ZEROS) begin
          slot16_all_ones_flag <= 1'b0;
        end
      end else begin
        ts16_zero_bits <= next_ts16_bits;
      end
    end
  end

  // transmit line short and zero-run supervision
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      tx_line_short_flag <= 1'b0;
      xls_cnt <= '0;
      tx_zero_run_flag <= 1'b0;
      xlo_cnt <= '0;
    end else begin
      if (!tx_ev_in.limiter_on) begin
        tx_line_short_flag <= 1'b0;
        xls_cnt <= '0;
      end else if (tx_ev_in.bit_strobe) begin
        if (!tx_ev_in.current_high) begin
          xls_cnt <= '0;
        end else if (xls_cnt == `EAM_XLS_PERIODS) begin
          tx_line_short_flag <= 1'b1;
        end else begin
          xls_cnt <= xls_cnt + 2'h1;
        end
      end
      if (tx_ev_in.bit_strobe) begin
        if (tx_ev_in.bit_pulse) begin
          xlo_cnt <= '0;
          tx_zero_run_flag <= 1'b0;
        end else if (xlo_cnt == `EAM_XLO_ZEROS - 6'h01) begin
          tx_zero_run_flag <= 1'b1;
          xlo_cnt <= `EAM_XLO_ZEROS - 6'h01;
        end else begin
          xlo_cnt <= xlo_cnt + 6'h01;
        end
      end
    end
  end

  // status mirror, one cycle behind the alarm state
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      status <= '0;
    end else begin
      status[`EAM_S_AIS] <= ais_state_flag;
      status[`EAM_S_LOS] <= (los_state == EAM_LOS_SET);
      status[`EAM_S_RRA] <= remote_alarm_flag;
      status[`EAM_S_AIS16] <= slot16_all_ones_flag;
      status[`EAM_S_LOS16] <= slot16_silence_flag;
      status[`EAM_S_RA16] <= slot16_far_alarm_flag;
      status[`EAM_S_XLS] <= tx_line_short_flag;
      status[`EAM_S_XLO] <= tx_zero_run_flag;
      status[`EAM_S_SI1] <= rx_submf1_err_flag;
      status[`EAM_S_SI2] <= rx_submf2_err_flag;
    end
  end

  // interrupt events: transitions between alarm state and its mirror, plus receive and transmit multiframe begins
  always_comb begin
    irq_set = '0;
    irq_set[`EAM_I_AIS] = ais_state_flag ^ status[`EAM_S_AIS];
    irq_set[`EAM_I_LOS] = (los_state == EAM_LOS_SET) ^ status[`EAM_S_LOS];
    irq_set[`EAM_I_RA] = remote_alarm_flag && !status[`EAM_S_RRA];
    irq_set[`EAM_I_RAR] = !remote_alarm_flag && status[`EAM_S_RRA];
    irq_set[`EAM_I_AIS16] = slot16_all_ones_flag ^ status[`EAM_S_AIS16];
    irq_set[`EAM_I_RA16] = slot16_far_alarm_flag ^ status[`EAM_S_RA16];
    irq_set[`EAM_I_XLSC] = (tx_line_short_flag ^ status[`EAM_S_XLS]) ||
                           (tx_zero_run_flag ^ status[`EAM_S_XLO]);
    irq_set[`EAM_I_RMB] = rx_ev_in.mf_begin;
    irq_set[`EAM_I_XMB] = tx_ev_in.mf_begin;
  end

  // sticky flags, write one to clear, a new event wins over the clear
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      irq <= '0;
    end else if (wr_irq) begin
      irq <= (irq & ~reg_wdata_in[`EAM_IRQ_W-1:0]) | irq_set;
    end else begin
      irq <= irq | irq_set;
    end
  end

  // slip keeps the signaling freeze until the next cas multiframe ends
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      slip_hold <= 1'b0;
    end else if (rx_ev_in.slip) begin
      slip_hold <= 1'b1;
    end else if (rx_ev_in.cas_end) begin
      slip_hold <= 1'b0;
    end
  end

  // automatic reactions, all registered
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      ctl_out <= '0;
      ais_state_flag_out <= 1'b0;
      signal_lost_flag_out <= 1'b0;
    end else begin
      if (rx_ev_in.frame_lost || rx_ev_in.mframe_lost) begin
        ctl_out.ebit13 <= ctrl[`EAM_C_EBP];
        ctl_out.ebit15 <= ctrl[`EAM_C_EBP];
      end else if (ctrl[`EAM_C_AXS]) begin
        // polarity select plays no part here
        ctl_out.ebit13 <= !rx_submf1_err_flag;
        ctl_out.ebit15 <= !rx_submf2_err_flag;
      end else begin
        ctl_out.ebit13 <= ctrl[`EAM_C_TX_EBIT_FRAME13];
        ctl_out.ebit15 <= ctrl[`EAM_C_TX_EBIT_FRAME15];
      end
      ctl_out.ebit_transparent <= ctrl[`EAM_C_TSIS];
      ctl_out.remote_alarm <= ctrl[`EAM_C_AXRA] ? rx_ev_in.frame_lost :
                              ctrl[`EAM_C_XRA];
      ctl_out.send_all_ones <= ctrl[`EAM_C_XAIS];
      ctl_out.slot16_far_alarm <= ctrl[`EAM_C_RA16];
      ctl_out.rx_force_ais <= rx_ev_in.frame_lost && !ctrl[`EAM_C_DAIS];
      ctl_out.dco_master <= ctrl[`EAM_C_MAS] ||
                            ((los_state == EAM_LOS_SET) && !ctrl[`EAM_C_DCS]);
      ctl_out.sig_freeze <= !ctrl[`EAM_C_DAF] && ((los_state == EAM_LOS_SET) ||
                            rx_ev_in.cas_lost || rx_ev_in.slip || slip_hold);
      ais_state_flag_out <= ais_state_flag;
      signal_lost_flag_out <= (los_state == EAM_LOS_SET);
    end
  end

  // read port: data only in the cycle after the strobe, unmapped reads zero
  always_ff @(posedge clk_in) begin
    if (reset_in || !reg_rd_in) begin
      reg_rdata_out <= 32'h0000_0000;
    end else if (reg_addr_in >= `EAM_ADDR_SIG_BASE && reg_addr_in <= `EAM_ADDR_SIG_LAST &&
                 reg_addr_in[1:0] == 2'h0) begin
      reg_rdata_out <= {24'h000000, sig_reg[reg_addr_in[5:2]]};
    end else begin
      unique case (reg_addr_in)
        `EAM_ADDR_CTRL: reg_rdata_out <= 32'(ctrl);
        `EAM_ADDR_LOS_CFG: reg_rdata_out <= {12'h000, los_ones_need, los_window};
        `EAM_ADDR_STATUS: reg_rdata_out <= 32'(status);
        `EAM_ADDR_IRQ: reg_rdata_out <= 32'(irq);
        `EAM_ADDR_EBIT_CNT: reg_rdata_out <= 32'(ebit_zero_counter);
        default: reg_rdata_out <= 32'h0000_0000;
      endcase
    end
  end

endmodule

// file: src/eam_pkg.sv
// Purpose: types for the e1 alarm and e-bit monitor
// Assumes: framer supplies one-cycle event strobes
// Notes: events travel as packed structs
package eam_pkg;

  // receive-side events and levels from the framer core
  typedef struct packed {
    logic bit_strobe;    // one received pulse period
    logic bit_one;       // pulse above threshold in that period
    logic frame_lost;    // basic frame alignment lost, level
    logic mframe_lost;   // crc multiframe alignment lost, level
    logic cas_lost;      // cas multiframe alignment lost, level
    logic nfas_strobe;   // time-slot-0 octet without alignment word
    logic nfas_bit3;
    logic smf_strobe;    // crc check of a submultiframe done
    logic smf_second;    // 0 first, 1 second submultiframe
    logic smf_error;
    logic ebit_strobe;   // received e-bit of frame 13 or 15
    logic ebit_value;
    logic ts16_strobe;   // received time-slot-16 octet
    logic [7:0] ts16_data;
    logic mfaw_strobe;   // cas multiframe alignment word seen
    logic mfaw_y;
    logic cas_end;       // end of a cas multiframe
    logic slip;          // receive slip
    logic mf_begin;      // receive multiframe begin
  } eam_rx_ev_t;

  // transmit-side events and levels
  typedef struct packed {
    logic bit_strobe;    // one transmitted pulse period
    logic bit_pulse;     // a pulse was sent
    logic current_high;  // greatly raised line current
    logic limiter_on;    // current limiter active
    logic mf_begin;      // transmit multiframe begin
  } eam_tx_ev_t;

  // automatic reactions toward the rest of the framer
  typedef struct packed {
    logic ebit13;
    logic ebit15;
    logic ebit_transparent;
    logic remote_alarm;
    logic send_all_ones;
    logic slot16_far_alarm;
    logic rx_force_ais;
    logic dco_master;
    logic sig_freeze;
  } eam_ctl_t;

  typedef enum logic {EAM_LOS_CLEAR, EAM_LOS_SET} eam_los_st_t;

endpackage
